//--- hw/uni_cfg_cellbus.sv
// Mode configuration registers and multi-PHY cell bus polling
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps

// Notes on behaviour
// (R1) Cell mode is the power-on system interface unless packet mode chosen.
// (R2) Reset comes from the low reset pin or the soft reset bit.
// (R3) Mode bit at 02: 0 selects cells, 1 selects packets.
// (R4) Software should load label 0x13 for cell payloads.
// (R5) Software should load label 0x16 or 0xCF for packet payloads.
// (R6) FIFOs of a channel stay cleared while its clear bit is set.
// (R7) Software clears monitoring counters through the transfer trigger bit.
// (R8) Offset byte insert disable at 0x82 forces H4 to 0x00.
// (R9) Overhead handling powers up as SONET; SDH only by registers.
// (R10) SS check at 0x3D demands received SS bits equal 10.
// (R11) Trace length bits choose 64 bytes when 0, 16 bytes when 1.
// (R12) Transmit SS field at 0x46: 00 for SONET, 10 for SDH.
// (R13) Growth byte insert 0 makes Z0 carry its column number.
// (R14) Voltage select at 0x01 switches all channels to 5V links.
// (R15) Polled transmit address answers whether that PHY takes a cell.
// (R16) Transmit address one cycle before enable selects the destination.
// (R17) Polling order is free and may restart during a transfer.
// (R18) Transmit cell-available driven only on an own address match.
// (R19) Receive address before enable selects who drives data lines.
// (R20) Receive cell-available driven only on an own address match.
module uni_cfg_cellbus
   import uni_cfg_pkg::*;
#(
   parameter logic [PHY_ADDR_W-1:0] PHY_BASE = 5'h00,
   parameter logic [3:0] IDENT_CODE = IDENT_DEFAULT
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic resetPinN,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [DATA_W-1:0] regRdData_q,
   input wire logic [PHY_ADDR_W-1:0] txPhyAddress,
   input wire logic txEnableN,
   input wire logic [NUM_CHAN-1:0] txSpace,
   output logic txCellAvailable_q,
   output logic txCellAvailableOe_q,
   output chan_sel_s txSel_q,
   input wire logic [PHY_ADDR_W-1:0] rxPhyAddress,
   input wire logic rxEnableN,
   input wire logic [NUM_CHAN-1:0] rxCellReady,
   input rx_word_s [NUM_CHAN-1:0] rxChanWord,
   output logic rxCellAvailable_q,
   output logic rxCellAvailableOe_q,
   output rx_word_s rxCellWord_q,
   output logic rxCellWordOe_q,
   output logic [NUM_CHAN-1:0] rxReadStrobe_q,
   output logic cellPacketSelect_q,
   output logic opticalLinkVoltageSelect_q,
   output logic [NUM_CHAN-1:0] fifoClear_q,
   output logic counterTransferTrigger_q,
   input wire logic [1:0] rxSsBits,
   output logic ssMismatch_q,
   output logic [1:0] txSsBits_q,
   output logic [DATA_W-1:0] pathSignalLabel_q,
   output logic [6:0] pathTraceLen_q,
   output logic [6:0] sectTraceLen_q,
   input wire logic [7:0] cellOffset,
   output logic [7:0] h4Byte_q,
   input wire logic [7:0] z0Column,
   output logic [7:0] z0Byte_q
);
   // ----------------------------------------------------------------
   // Reset and register writes
   // ----------------------------------------------------------------
   logic softReset_q;
   logic rst;
   logic pathShort_q;
   logic sectShort_q;
   logic ssCheckEnable_q;
   logic offsetByteInsertDisable_q;
   logic growthByteInsert_q;
   logic [NUM_CHAN-1:0] clearDone;
   logic [HOLD_W-1:0] holdCnt_q [NUM_CHAN];

   assign rst = sys_rst | ~resetPinN | softReset_q; // [R2]

   // Soft reset is a one-cycle pulse so the bit reads back as zero
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !resetPinN) begin
         softReset_q <= 1'b0;
      end else begin
         softReset_q <= regWr && regAddr == ADDR_RESET_IDENT
            && regWrData[BIT_SOFT_RESET]; // [R2]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cellPacketSelect_q <= 1'b0; // [R1]
         opticalLinkVoltageSelect_q <= 1'b0;
         fifoClear_q <= '0;
         growthByteInsert_q <= 1'b0;
         pathShort_q <= 1'b0; // [R9]
         sectShort_q <= 1'b0;
         ssCheckEnable_q <= 1'b0;
         txSsBits_q <= RST_TX_SS;
         pathSignalLabel_q <= RST_LABEL;
         offsetByteInsertDisable_q <= 1'b0;
      end else if (regWr) begin
         unique case (regAddr)
            ADDR_MASTER_CFG: begin
               opticalLinkVoltageSelect_q <= regWrData[BIT_VOLT_SEL]; // [R14]
            end
            ADDR_SYS_IF_CTRL: begin
               cellPacketSelect_q <= regWrData[BIT_CELL_PKT]; // [R3]
            end
            ADDR_FIFO_CTRL: begin
               fifoClear_q <= regWrData[FIFO_HI:FIFO_LO]; // [R6]
               growthByteInsert_q <= regWrData[BIT_GROWTH_INS];
            end
            ADDR_PATH_TRACE: begin
               pathShort_q <= regWrData[BIT_SHORT_TRACE];
            end
            ADDR_SS_DETECT: begin
               ssCheckEnable_q <= regWrData[BIT_SS_CHECK];
            end
            ADDR_TX_SS_BITS: begin
               txSsBits_q <= regWrData[1:0]; // [R12]
            end
            ADDR_PATH_LABEL: begin
               pathSignalLabel_q <= regWrData; // [R4] [R5]
            end
            ADDR_SECT_TRACE: begin
               sectShort_q <= regWrData[BIT_SHORT_TRACE];
            end
            ADDR_CELL_OPTIONS: begin
               offsetByteInsertDisable_q <= regWrData[BIT_H4_DISABLE];
            end
            default: begin
            end
         endcase
      end
   end

   // Transfer trigger is a pulse; counters latch and clear on it
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         counterTransferTrigger_q <= 1'b0;
      end else begin
         counterTransferTrigger_q <= regWr && regAddr == ADDR_COUNTER_CTRL
            && regWrData[BIT_COUNT_XFER]; // [R7]
      end
   end

   // ----------------------------------------------------------------
   // FIFO clear hold time, per channel
   // ----------------------------------------------------------------
   // Status only: an early release still clears, software must check
   for (genvar c = 0; c < NUM_CHAN; c++) begin : g_hold
      always_ff @(posedge ref_clk) begin
         if (rst || !fifoClear_q[c]) begin
            holdCnt_q[c] <= '0;
         end else if (holdCnt_q[c] != HOLD_W'(FIFO_CLEAR_CYC)) begin
            holdCnt_q[c] <= holdCnt_q[c] + 1'b1; // [R6]
         end
      end
      assign clearDone[c] = holdCnt_q[c] == HOLD_W'(FIFO_CLEAR_CYC);
   end

   // ----------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         regRdData_q <= '0;
      end else if (regRd) begin
         unique case (regAddr)
            ADDR_RESET_IDENT: regRdData_q <= {4'h0, IDENT_CODE};
            ADDR_MASTER_CFG: regRdData_q <= {7'h00,
               opticalLinkVoltageSelect_q};
            ADDR_SYS_IF_CTRL: regRdData_q <= {7'h00, cellPacketSelect_q};
            ADDR_FIFO_CTRL: regRdData_q <= {clearDone[NUM_CHAN-1:1],
               growthByteInsert_q, fifoClear_q};
            ADDR_COUNTER_CTRL: regRdData_q <= {6'h00, ssMismatch_q, 1'b0};
            ADDR_PATH_TRACE: regRdData_q <= {7'h00, pathShort_q};
            ADDR_SS_DETECT: regRdData_q <= {7'h00, ssCheckEnable_q};
            ADDR_TX_SS_BITS: regRdData_q <= {6'h00, txSsBits_q};
            ADDR_PATH_LABEL: regRdData_q <= pathSignalLabel_q;
            ADDR_SECT_TRACE: regRdData_q <= {7'h00, sectShort_q};
            ADDR_CELL_OPTIONS: regRdData_q <= {7'h00,
               offsetByteInsertDisable_q};
            default: regRdData_q <= '0;
         endcase
      end else begin
         regRdData_q <= '0;
      end
   end

   // ----------------------------------------------------------------
   // SONET / SDH overhead settings
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ssMismatch_q <= 1'b0;
         pathTraceLen_q <= TRACE_LONG;
         sectTraceLen_q <= TRACE_LONG;
         h4Byte_q <= H4_FORCED;
         z0Byte_q <= Z0_RESERVED;
      end else begin
         ssMismatch_q <= ssCheckEnable_q && rxSsBits != SS_SDH_CODE; // [R10]
         pathTraceLen_q <= pathShort_q ? TRACE_SHORT : TRACE_LONG; // [R11]
         sectTraceLen_q <= sectShort_q ? TRACE_SHORT : TRACE_LONG; // [R11]
         h4Byte_q <= offsetByteInsertDisable_q ? H4_FORCED
            : cellOffset; // [R8]
         z0Byte_q <= growthByteInsert_q ? Z0_RESERVED : z0Column; // [R13]
      end
   end

   // ----------------------------------------------------------------
   // Cell bus address decode
   // ----------------------------------------------------------------
   // Bus only active in cell mode; packet transfer is handled elsewhere
   logic [PHY_ADDR_W-1:0] txOfs;
   logic [PHY_ADDR_W-1:0] rxOfs;
   logic txMatch;
   logic rxMatch;
   logic [PHY_ADDR_W-1:0] txAddrPrev_q;
   logic [PHY_ADDR_W-1:0] rxAddrPrev_q;
   logic txEnPrevN_q;
   logic rxEnPrevN_q;
   logic [PHY_ADDR_W-1:0] txPrevOfs;
   logic [PHY_ADDR_W-1:0] rxPrevOfs;
   chan_sel_s rxSel_q;

   assign txOfs = txPhyAddress - PHY_BASE;
   assign rxOfs = rxPhyAddress - PHY_BASE;
   assign txMatch = !cellPacketSelect_q && txOfs < PHY_ADDR_W'(NUM_CHAN);
   assign rxMatch = !cellPacketSelect_q && rxOfs < PHY_ADDR_W'(NUM_CHAN);
   assign txPrevOfs = txAddrPrev_q - PHY_BASE;
   assign rxPrevOfs = rxAddrPrev_q - PHY_BASE;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         // Low, so an enable held low across reset is no new selection
         txAddrPrev_q <= '0;
         rxAddrPrev_q <= '0;
         txEnPrevN_q <= 1'b0;
         rxEnPrevN_q <= 1'b0;
      end else begin
         txAddrPrev_q <= txPhyAddress;
         rxAddrPrev_q <= rxPhyAddress;
         txEnPrevN_q <= txEnableN;
         rxEnPrevN_q <= rxEnableN;
      end
   end

   // Polling answers follow the address by one cycle; any order allowed
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         txCellAvailable_q <= 1'b0;
         txCellAvailableOe_q <= 1'b0;
         rxCellAvailable_q <= 1'b0;
         rxCellAvailableOe_q <= 1'b0;
      end else begin
         txCellAvailableOe_q <= txMatch; // [R18] [R17]
         txCellAvailable_q <= txMatch && txSpace[txOfs[1:0]]; // [R15]
         rxCellAvailableOe_q <= rxMatch; // [R20]
         rxCellAvailable_q <= rxMatch && rxCellReady[rxOfs[1:0]]; // [R20]
      end
   end

   // Selection taken from the address held the cycle before enable falls
   always_ff @(posedge ref_clk) begin
      if (rst || cellPacketSelect_q) begin
         txSel_q <= '0;
      end else if (txEnPrevN_q && !txEnableN) begin
         txSel_q.valid <= txPrevOfs < PHY_ADDR_W'(NUM_CHAN); // [R16]
         txSel_q.chan <= txPrevOfs[1:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst || cellPacketSelect_q) begin
         rxSel_q <= '0;
      end else if (rxEnPrevN_q && !rxEnableN) begin
         rxSel_q.valid <= rxPrevOfs < PHY_ADDR_W'(NUM_CHAN); // [R19]
         rxSel_q.chan <= rxPrevOfs[1:0];
      end
   end

   // Data lines follow the selection; unselected keeps them released
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rxCellWord_q <= '0;
         rxCellWordOe_q <= 1'b0;
         rxReadStrobe_q <= '0;
      end else begin
         rxCellWordOe_q <= rxSel_q.valid; // [R19]
         rxCellWord_q <= rxSel_q.valid ? rxChanWord[rxSel_q.chan] : '0;
         for (int c = 0; c < NUM_CHAN; c++) begin
            rxReadStrobe_q[c] <= rxSel_q.valid && !rxEnableN
               && rxSel_q.chan == 2'(c);
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_tx_avail_drive: assert property ( // [R18]
      txMatch |=> txCellAvailableOe_q)
      else $error("tx cell-available not driven on own address");
   a_tx_avail_release: assert property ( // [R18]
      !txMatch |=> !txCellAvailableOe_q && !txCellAvailable_q)
      else $error("tx cell-available driven on foreign address");
   a_tx_avail_answer: assert property ( // [R15]
      txMatch |=> txCellAvailable_q == $past(txSpace[txOfs[1:0]]))
      else $error("tx cell-available does not show space");
   a_rx_avail_drive: assert property ( // [R20]
      rxMatch |=> rxCellAvailableOe_q
         && rxCellAvailable_q == $past(rxCellReady[rxOfs[1:0]]))
      else $error("rx cell-available wrong on own address");
   a_rx_data_select: assert property ( // [R19]
      (rxEnPrevN_q && !rxEnableN && !cellPacketSelect_q
         && rxPrevOfs >= PHY_ADDR_W'(NUM_CHAN)) |=> ##1 !rxCellWordOe_q)
      else $error("rx data driven after foreign selection");
   a_tx_select: assert property ( // [R16]
      (txEnPrevN_q && !txEnableN && !cellPacketSelect_q
         && txPrevOfs < PHY_ADDR_W'(NUM_CHAN))
      |=> txSel_q.valid && txSel_q.chan == $past(txPrevOfs[1:0]))
      else $error("tx destination not taken from prior address");
   a_h4_forced: assert property ( // [R8]
      offsetByteInsertDisable_q && $past(offsetByteInsertDisable_q)
      |-> h4Byte_q == H4_FORCED)
      else $error("H4 not zero while insert disabled");
   a_ss_check: assert property ( // [R10]
      (ssCheckEnable_q && rxSsBits != SS_SDH_CODE) |=> ssMismatch_q)
      else $error("SS mismatch not flagged");
   a_trace_short: assert property ( // [R11]
      pathShort_q ##1 pathShort_q |-> pathTraceLen_q == TRACE_SHORT)
      else $error("path trace length not 16");
   a_mode_write: assert property ( // [R3]
      regWr && regAddr == ADDR_SYS_IF_CTRL
      |=> cellPacketSelect_q == $past(regWrData[BIT_CELL_PKT]))
      else $error("mode bit not written");
   a_hold_count: assert property ( // [R6]
      fifoClear_q[0] [*8] |-> holdCnt_q[0] >= HOLD_W'(7))
      else $error("fifo clear hold count stalled");
   a_soft_reset: assert property ( // [R2]
      disable iff (sys_rst || !resetPinN)
      regWr && regAddr == ADDR_RESET_IDENT && regWrData[BIT_SOFT_RESET]
      |=> softReset_q ##1 pathSignalLabel_q == RST_LABEL)
      else $error("soft reset bit did not clear registers");
   a_pkt_bus_quiet: assert property ( // [R3]
      cellPacketSelect_q |=> !txCellAvailableOe_q && !rxCellAvailableOe_q)
      else $error("cell bus driven in packet mode");
   a_rx_select_own: assert property ( // [R19]
      (rxEnPrevN_q && !rxEnableN && !cellPacketSelect_q
         && rxPrevOfs < PHY_ADDR_W'(NUM_CHAN)) |=> ##1 rxCellWordOe_q)
      else $error("rx data not driven after own selection");
   a_rx_avail_release: assert property ( // [R20]
      !rxMatch |=> !rxCellAvailableOe_q && !rxCellAvailable_q)
      else $error("rx cell-available driven on foreign address");
   a_volt_write: assert property ( // [R14]
      regWr && regAddr == ADDR_MASTER_CFG
      |=> opticalLinkVoltageSelect_q == $past(regWrData[BIT_VOLT_SEL]))
      else $error("voltage select bit not written");
   a_z0_column: assert property ( // [R13]
      !growthByteInsert_q |=> z0Byte_q == $past(z0Column))
      else $error("Z0 does not carry the column number");

   c_tx_select: cover property (txEnPrevN_q && !txEnableN && txMatch);
   c_rx_drive: cover property (rxCellWordOe_q && !rxEnableN);
   c_packet_mode: cover property (cellPacketSelect_q);
   c_clear_done: cover property (clearDone[0]);
endmodule

//--- hw/uni_cfg_pkg.sv
// Package: register map, field layout, timing and bus carriers
package uni_cfg_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int NUM_CHAN = 4;
   localparam int PHY_ADDR_W = 5;
   localparam int CELL_DATA_W = 16;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_RESET_IDENT = 8'h00;
   localparam logic [7:0] ADDR_MASTER_CFG = 8'h01;
   localparam logic [7:0] ADDR_SYS_IF_CTRL = 8'h02;
   localparam logic [7:0] ADDR_FIFO_CTRL = 8'h04;
   localparam logic [7:0] ADDR_COUNTER_CTRL = 8'h05;
   localparam logic [7:0] ADDR_PATH_TRACE = 8'h28;
   localparam logic [7:0] ADDR_SS_DETECT = 8'h3d;
   localparam logic [7:0] ADDR_TX_SS_BITS = 8'h46;
   localparam logic [7:0] ADDR_PATH_LABEL = 8'h48;
   localparam logic [7:0] ADDR_SECT_TRACE = 8'h50;
   localparam logic [7:0] ADDR_CELL_OPTIONS = 8'h82;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int BIT_SOFT_RESET = 7;
   localparam int BIT_VOLT_SEL = 0;
   localparam int BIT_CELL_PKT = 0;
   localparam int BIT_GROWTH_INS = 4;
   localparam int BIT_COUNT_XFER = 0;
   localparam int BIT_SHORT_TRACE = 0;
   localparam int BIT_SS_CHECK = 0;
   localparam int BIT_H4_DISABLE = 0;
   localparam int FIFO_LO = 0;
   localparam int FIFO_HI = 3;
   localparam int DONE_LO = 4;

   // ----------------------------------------------------------------
   // Reset values and codes
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_LABEL = 8'h00;
   localparam logic [1:0] RST_TX_SS = 2'h0;
   localparam logic [1:0] SS_SDH_CODE = 2'h2;
   localparam logic [7:0] H4_FORCED = 8'h00;
   localparam logic [7:0] Z0_RESERVED = 8'h00;
   localparam logic [6:0] TRACE_LONG = 7'h40;
   localparam logic [6:0] TRACE_SHORT = 7'h10;
   localparam logic [3:0] IDENT_DEFAULT = 4'h5; // arbitrary value

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int FIFO_CLEAR_MIN_NS = 1000;
   localparam int FIFO_CLEAR_CYC =
      (FIFO_CLEAR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_W = $clog2(FIFO_CLEAR_CYC + 1);

   typedef struct packed {
      logic [CELL_DATA_W-1:0] data;
      logic startOfCell;
      logic parity;
   } rx_word_s;

   typedef struct packed {
      logic valid;
      logic [1:0] chan;
   } chan_sel_s;
endpackage

//--- tb/atm_layer_model.sv
// ATM layer model that polls and selects PHYs on the cell bus
`timescale 1ns/1ps
module atm_layer_model
   import uni_cfg_pkg::*;
(
   input wire logic ref_clk,
   output logic [PHY_ADDR_W-1:0] txPhyAddress,
   output logic txEnableN,
   output logic [PHY_ADDR_W-1:0] rxPhyAddress,
   output logic rxEnableN
);
   // ---------------------------------------------------------------
   // Bus master actions
   // ---------------------------------------------------------------
   // Park on a foreign address so no PHY drives at start
   initial begin
      txPhyAddress = 5'h1f;
      rxPhyAddress = 5'h1f;
      txEnableN = 1'b1;
      rxEnableN = 1'b1;
   end

   // Free poll order, also while a transfer runs
   task automatic poll(input logic [4:0] ta, input logic [4:0] ra);
      @(posedge ref_clk);
      txPhyAddress <= ta;
      rxPhyAddress <= ra;
   endtask

   // Address stands one cycle before the enable falls
   task automatic pick(input logic [4:0] ta, input logic [4:0] ra);
      @(posedge ref_clk);
      txPhyAddress <= ta;
      rxPhyAddress <= ra;
      txEnableN <= 1'b1;
      rxEnableN <= 1'b1;
      @(posedge ref_clk);
      txEnableN <= 1'b0;
      rxEnableN <= 1'b0;
   endtask
endmodule

//--- tb/uni_cfg_cellbus_tb.sv
// Self-checking bench for mode registers and cell bus polling
`timescale 1ns/1ps
module uni_cfg_cellbus_tb
   import uni_cfg_pkg::*;
;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic resetPinN = 1'b1;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic [7:0] cellOffset = 8'h5a;
   logic [7:0] z0Column = 8'h07;
   logic [3:0] txSpace = 4'ha;
   logic [3:0] rxCellReady = 4'h5;
   logic [1:0] rxSsBits = 2'h0;
   rx_word_s [NUM_CHAN-1:0] rxChanWord =
      {18'h0abcd, 18'h31234, 18'h25678, 18'h19abc};
   logic [7:0] regRdData_q, pathSignalLabel_q, h4Byte_q, z0Byte_q;
   logic [4:0] txPhyAddress, rxPhyAddress;
   logic txEnableN, rxEnableN, txCellAvailable_q, txCellAvailableOe_q;
   logic rxCellAvailable_q, rxCellAvailableOe_q, rxCellWordOe_q;
   logic cellPacketSelect_q, opticalLinkVoltageSelect_q;
   logic counterTransferTrigger_q, ssMismatch_q;
   logic [3:0] rxReadStrobe_q, fifoClear_q;
   logic [1:0] txSsBits_q;
   logic [6:0] pathTraceLen_q, sectTraceLen_q;
   chan_sel_s txSel_q;
   rx_word_s rxCellWord_q;
   int err_count = 0;
   int num_checks = 0;
   int cycles = 0;

   always #10 ref_clk = ~ref_clk;

   uni_cfg_cellbus uni_cfg_cellbus_i (
      .ref_clk, .sys_rst, .resetPinN, .regAddr, .regWrData, .regWr,
      .regRd, .regRdData_q, .txPhyAddress, .txEnableN, .txSpace,
      .txCellAvailable_q, .txCellAvailableOe_q, .txSel_q, .rxPhyAddress,
      .rxEnableN, .rxCellReady, .rxChanWord, .rxCellAvailable_q,
      .rxCellAvailableOe_q, .rxCellWord_q, .rxCellWordOe_q,
      .rxReadStrobe_q, .cellPacketSelect_q, .opticalLinkVoltageSelect_q,
      .fifoClear_q, .counterTransferTrigger_q, .rxSsBits, .ssMismatch_q,
      .txSsBits_q, .pathSignalLabel_q, .pathTraceLen_q, .sectTraceLen_q,
      .cellOffset, .h4Byte_q, .z0Column, .z0Byte_q
   );

   atm_layer_model atm_layer_model_i (
      .ref_clk, .txPhyAddress, .txEnableN, .rxPhyAddress, .rxEnableN
   );

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [17:0] seen,
                        input logic [17:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Sample mid-cycle so registered outputs have settled
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge ref_clk);
      regWr <= 1'b0;
      @(negedge ref_clk);
   endtask

   // Read data stand in one cycle only, so look there
   task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                     input string what);
      @(posedge ref_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge ref_clk);
      regRd <= 1'b0;
      @(negedge ref_clk);
      check(what, regRdData_q, exp);
   endtask

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic resetValues();
      check("mode", cellPacketSelect_q, 1'b0);
      check("pathLen", pathTraceLen_q, TRACE_LONG);
      check("sectLen", sectTraceLen_q, TRACE_LONG);
      check("txSs", txSsBits_q, RST_TX_SS);
      check("volt", opticalLinkVoltageSelect_q, 1'b0);
      rd(ADDR_RESET_IDENT, {4'h0, IDENT_DEFAULT}, "ident");
      rd(8'h7f, 8'h00, "unmapped");
   endtask

   task automatic polling();
      for (int a = 0; a < 6; a++) begin
         atm_layer_model_i.poll(a[4:0], 5'(5 - a));
         tick(1);
         check("txOe", txCellAvailableOe_q, a < 4);
         check("txCa", txCellAvailable_q, a < 4 && txSpace[a % 4]);
         check("rxOe", rxCellAvailableOe_q, 5 - a < 4);
         check("rxCa", rxCellAvailable_q,
               5 - a < 4 && rxCellReady[(5 - a) % 4]);
      end
   endtask

   task automatic selecting();
      atm_layer_model_i.pick(5'h03, 5'h02);
      tick(2);
      check("txSel", txSel_q, 3'b111);
      check("rdOe", rxCellWordOe_q, 1'b1);
      check("rdWord", rxCellWord_q, rxChanWord[2]);
      check("rdStrobe", rxReadStrobe_q, 4'h4);
      atm_layer_model_i.poll(5'h01, 5'h00);
      tick(1);
      check("rePoll", rxCellAvailable_q, rxCellReady[0]);
      check("stillSel", rxCellWordOe_q, 1'b1);
      atm_layer_model_i.pick(5'h1f, 5'h1f);
      tick(2);
      check("deselRx", rxCellWordOe_q, 1'b0);
      check("deselTx", txSel_q.valid, 1'b0);
   endtask

   task automatic modeLabel();
      logic [7:0] lab [3] = '{8'h13, 8'h16, 8'hcf};
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_SYS_IF_CTRL, {7'h0, i != 0});
         wr(ADDR_PATH_LABEL, lab[i]);
         check("label", pathSignalLabel_q, lab[i]);
         check("mode", cellPacketSelect_q, i != 0);
         rd(ADDR_PATH_LABEL, lab[i], "labelRd");
      end
      // Packet mode must keep the cell bus quiet
      atm_layer_model_i.poll(5'h01, 5'h01);
      tick(1);
      check("pktTxOe", txCellAvailableOe_q, 1'b0);
      wr(ADDR_SYS_IF_CTRL, 8'h00);
   endtask

   task automatic sdhMode();
      wr(ADDR_PATH_TRACE, 8'h01);
      wr(ADDR_SECT_TRACE, 8'h01);
      wr(ADDR_TX_SS_BITS, {6'h0, SS_SDH_CODE});
      wr(ADDR_SS_DETECT, 8'h01);
      tick(2);
      check("pathLen", pathTraceLen_q, TRACE_SHORT);
      check("sectLen", sectTraceLen_q, TRACE_SHORT);
      check("txSs", txSsBits_q, SS_SDH_CODE);
      check("ssBad", ssMismatch_q, 1'b1);
      rd(ADDR_COUNTER_CTRL, 8'h02, "ssBadRd");
      @(posedge ref_clk);
      rxSsBits <= SS_SDH_CODE;
      tick(2);
      check("ssGood", ssMismatch_q, 1'b0);
      rd(ADDR_TX_SS_BITS, {6'h0, SS_SDH_CODE}, "txSsRd");
      wr(ADDR_SS_DETECT, 8'h00);
      @(posedge ref_clk);
      rxSsBits <= 2'h0;
      tick(2);
      check("ssOff", ssMismatch_q, 1'b0);
   endtask

   task automatic options();
      wr(ADDR_MASTER_CFG, 8'h01);
      check("volt", opticalLinkVoltageSelect_q, 1'b1);
      check("h4", h4Byte_q, cellOffset);
      wr(ADDR_CELL_OPTIONS, 8'h01);
      tick(1);
      check("h4Zero", h4Byte_q, H4_FORCED);
      check("z0", z0Byte_q, z0Column);
      wr(ADDR_FIFO_CTRL, 8'h1f);
      tick(1);
      check("z0Off", z0Byte_q, 8'h00);
      check("fifo", fifoClear_q, 4'hf);
      rd(ADDR_FIFO_CTRL, 8'h1f, "fifoBusy");
      tick(FIFO_CLEAR_CYC);
      check("fifoHold", fifoClear_q, 4'hf);
      rd(ADDR_FIFO_CTRL, 8'hff, "fifoDone");
      wr(ADDR_FIFO_CTRL, 8'h00);
      check("fifoOff", fifoClear_q, 4'h0);
      wr(ADDR_COUNTER_CTRL, 8'h01);
      check("xfer", counterTransferTrigger_q, 1'b1);
      tick(0);
      check("xferEnd", counterTransferTrigger_q, 1'b0);
   endtask

   task automatic resets();
      wr(ADDR_PATH_LABEL, 8'hcf);
      wr(ADDR_RESET_IDENT, 8'h80);
      tick(1);
      check("softRst", pathSignalLabel_q, RST_LABEL);
      wr(ADDR_SYS_IF_CTRL, 8'h01);
      wr(ADDR_MASTER_CFG, 8'h01);
      @(posedge ref_clk);
      resetPinN <= 1'b0;
      @(posedge ref_clk);
      resetPinN <= 1'b1;
      tick(1);
      check("pinRst", cellPacketSelect_q, 1'b0);
      check("pinRstVolt", opticalLinkVoltageSelect_q, 1'b0);
      tick(1);
      check("pinRstSel", rxCellWordOe_q, 1'b0);
   endtask

   // A hang never reaches the verdict on its own
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         conclude();
      end
   end

   initial begin
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      tick(1);
      resetValues();
      polling();
      selecting();
      modeLabel();
      sdhMode();
      options();
      resets();
      conclude();
   end
endmodule
